// ==== ccd_child_dec.sv ====
// Purpose: Child count decrement leaf of the virtualization enclave instruction.
// Assumes: Translation and page metadata lookups, and the locked counter,
//          live outside and answer over the request/response carriers.
// Notes:   Registers are reached over AHB-Lite; every answer is zero wait.
//
// Contract
// RQ1: Leaf index 00H in leaf select register selects it; feature bit 5 must be set.
// RQ2: Operation runs only at privilege level 0, else general-protection fault.
// RQ3: Linear addresses come from the data segment only; overrides are ignored.
// RQ4: Unaligned target page address gives general-protection fault before anything else; here the feature, leaf and privilege checks come first.
// RQ5: Address outside protected memory gives page fault with enclave code bit.
// RQ6: Target under concurrent modification: zero flag set, conflict code, skip to end.
// RQ7: Target metadata invalid gives page fault on target with enclave bit.
// RQ8: Child types take owning control page as parent; control type its own address.
// RQ9: Any other target type gives page fault; counter stays unchanged.
// RQ10: Derived parent not equal to parent operand address gives general-protection fault.
// RQ11: Parent operand not a control page gives page fault.
// RQ12: Locked decrement; on underflow locked increment back, zero flag, invalid-counter code.
// RQ13: Zero flag set only on conflict or underflow; success clears it, result 0.
// RQ14: 32-bit mode: limit overrun or unusable data segment gives general-protection fault.
// RQ15: 64-bit mode: non-canonical operand address gives general-protection fault.
// RQ16: Target requested as non-enclave read/write; parent as enclave read only.
// RQ17: Derived parent address and child count are held as 64-bit values.
// RQ18: Every non-faulting exit clears carry, parity, aux-carry, overflow and sign.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ccd_child_dec
  import ccd_pkg::*;
#(
  parameter bit FEATURE_EN = 1'b1,
  parameter int VA_BITS    = 48
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic      [31:0]   hrdata,
  output ccd_xlat_req_t      xlat_req,
  input  wire ccd_xlat_rsp_t xlat_rsp,
  output ccd_cnt_req_t       cnt_req,
  input  wire ccd_cnt_rsp_t  cnt_rsp,
  output logic               irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ccd_st_t       st;
    logic          go;
    logic [1:0]    cpl;
    logic          mode64;
    logic          ds_unusable;
    logic [31:0]   leaf;
    logic [63:0]   tgt;
    logic [63:0]   par;
    logic [31:0]   ds_base;
    logic [31:0]   ds_limit;
    logic [31:0]   result;
    logic [11:0]   flags;
    ccd_fault_t    fault_kind;
    logic [15:0]   fault_code;
    logic [63:0]   fault_addr;
    ccd_xlat_rsp_t t_info;
    ccd_xlat_rsp_t p_info;
    logic [63:0]   derived_parent_address;
    logic [63:0]   temp_child_count;
    logic          wr_pend;
    logic [7:0]    wr_addr;
    logic [31:0]   hrdata;
    logic          hreadyout;
    ccd_xlat_req_t xlat_req;
    ccd_cnt_req_t  cnt_req;
    logic          ev_done;
    logic          ev_fault;
  } ccd_state_t;

  ccd_state_t q;
  ccd_state_t d;

  logic [63:0]             tgt_lin;
  logic [63:0]             par_lin;
  logic                    tgt_seg_err;
  logic                    par_seg_err;
  logic [31:0]             rdata;
  logic [CCD_NUM_EV-1:0]   ev_vec;
  logic [CCD_NUM_EV-1:0]   w1c;
  logic                    mask_we;
  logic [CCD_NUM_EV-1:0]   irq_status;
  logic [CCD_NUM_EV-1:0]   irq_mask;
  logic                    addr_phase;
  logic                    flt;
  ccd_fault_t              flt_kind;
  logic [15:0]             flt_code;
  logic [63:0]             flt_addr;
  logic                    ext;
  logic                    ext_zf;
  logic [31:0]             ext_res;
  logic                    child_type;
  logic [63:0]             derived;

  // ****************************************
  // Operand address forming
  // ****************************************
  ccd_addr_check #(
    .VA_BITS (VA_BITS)
  ) u_tgt_chk (
    .operand     (q.tgt),
    .ds_base     (q.ds_base),
    .ds_limit    (q.ds_limit),
    .mode64      (q.mode64),
    .ds_unusable (q.ds_unusable),
    .lin         (tgt_lin),
    .seg_err     (tgt_seg_err)
  );

  ccd_addr_check #(
    .VA_BITS (VA_BITS)
  ) u_par_chk (
    .operand     (q.par),
    .ds_base     (q.ds_base),
    .ds_limit    (q.ds_limit),
    .mode64      (q.mode64),
    .ds_unusable (q.ds_unusable),
    .lin         (par_lin),
    .seg_err     (par_seg_err)
  );

  // ****************************************
  // Interrupt events
  // ****************************************
  assign ev_vec  = {q.ev_fault, q.ev_done};
  assign w1c     = (q.wr_pend && (q.wr_addr == CCD_OFF_STATUS)) ? hwdata[CCD_NUM_EV-1:0] : '0;
  assign mask_we = q.wr_pend && (q.wr_addr == CCD_OFF_MASK);

  ccd_irq #(
    .N (CCD_NUM_EV)
  ) u_irq (
    .clk        (clk),
    .srst       (srst),
    .event_in   (ev_vec),
    .w1c        (w1c),
    .mask_we    (mask_we),
    .mask_wdata (hwdata[CCD_NUM_EV-1:0]),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq        (irq)
  );

  // ****************************************
  // Register read mux
  // ****************************************
  assign addr_phase = hsel & hready & htrans[1];

  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr[7:0])
      CCD_OFF_CTRL: begin
        rdata[CCD_CTRL_CPL_LSB+:2]    = q.cpl;
        rdata[CCD_CTRL_MODE64]        = q.mode64;
        rdata[CCD_CTRL_DS_UNUSABLE]   = q.ds_unusable;
        rdata[CCD_CTRL_BUSY]          = (q.st != CCD_S_IDLE) | q.go;
      end
      CCD_OFF_LEAF:     rdata = q.leaf;
      CCD_OFF_TGT_LO:   rdata = q.tgt[31:0];
      CCD_OFF_TGT_HI:   rdata = q.tgt[63:32];
      CCD_OFF_PAR_LO:   rdata = q.par[31:0];
      CCD_OFF_PAR_HI:   rdata = q.par[63:32];
      CCD_OFF_DS_BASE:  rdata = q.ds_base;
      CCD_OFF_DS_LIMIT: rdata = q.ds_limit;
      CCD_OFF_RESULT:   rdata = q.result;
      CCD_OFF_FLAGS:    rdata[11:0] = q.flags;
      CCD_OFF_FAULT: begin
        rdata[1:0]                      = q.fault_kind;
        rdata[CCD_FAULT_CODE_LSB+:16]   = q.fault_code;
      end
      CCD_OFF_FADDR_LO: rdata = q.fault_addr[31:0];
      CCD_OFF_FADDR_HI: rdata = q.fault_addr[63:32];
      CCD_OFF_STATUS:   rdata[CCD_NUM_EV-1:0] = irq_status;
      CCD_OFF_MASK:     rdata[CCD_NUM_EV-1:0] = irq_mask;
      CCD_OFF_FEATURE:  rdata[CCD_FEAT_BIT] = FEATURE_EN; // RQ1
      default:          rdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Parent derivation
  // ****************************************
  always_comb begin
    child_type = (q.t_info.ptype == CCD_PT_REGULAR) | (q.t_info.ptype == CCD_PT_THREAD_CTRL) |
                 (q.t_info.ptype == CCD_PT_TRIMMED) | (q.t_info.ptype == CCD_FIRST_SHADOW_STACK_PAGE_TYPE) |
                 (q.t_info.ptype == CCD_PT_SS_LATER); // RQ8
    derived    = child_type ? q.t_info.owner : q.t_info.phys; // RQ8 RQ17
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d                = q;
    d.xlat_req.valid = 1'b0;
    d.cnt_req.valid  = 1'b0;
    d.ev_done        = 1'b0;
    d.ev_fault       = 1'b0;
    d.go             = 1'b0;
    d.hreadyout      = 1'b1;
    flt              = 1'b0;
    flt_kind         = CCD_FK_NONE;
    flt_code         = CCD_GP_CODE;
    flt_addr         = 64'h0;
    ext              = 1'b0;
    ext_zf           = 1'b0;
    ext_res          = CCD_RES_OK;

    // Data phase of a write.  Operand writes are refused while busy so a
    // running leaf never sees its inputs change under it.
    if (q.wr_pend && (q.st == CCD_S_IDLE) && !q.go) begin
      case (q.wr_addr)
        CCD_OFF_CTRL: begin
          d.cpl         = hwdata[CCD_CTRL_CPL_LSB+:2];
          d.mode64      = hwdata[CCD_CTRL_MODE64];
          d.ds_unusable = hwdata[CCD_CTRL_DS_UNUSABLE];
          d.go          = hwdata[CCD_CTRL_START];
        end
        CCD_OFF_LEAF:     d.leaf = hwdata;
        CCD_OFF_TGT_LO:   d.tgt[31:0] = hwdata;
        CCD_OFF_TGT_HI:   d.tgt[63:32] = hwdata;
        CCD_OFF_PAR_LO:   d.par[31:0] = hwdata;
        CCD_OFF_PAR_HI:   d.par[63:32] = hwdata;
        CCD_OFF_DS_BASE:  d.ds_base = hwdata;
        CCD_OFF_DS_LIMIT: d.ds_limit = hwdata;
        CCD_OFF_FLAGS:    d.flags = hwdata[11:0];
        default:          d.go = 1'b0;
      endcase
    end
    d.wr_pend = addr_phase & hwrite;
    d.wr_addr = haddr[7:0];
    if (addr_phase && !hwrite) begin
      d.hrdata = rdata;
    end

    case (q.st)
      CCD_S_IDLE: begin
        if (q.go) begin
          if (!FEATURE_EN) begin
            flt      = 1'b1; // RQ1
            flt_kind = CCD_FK_UD;
          end else if (q.leaf != CCD_LEAF_DEC) begin
            flt      = 1'b1; // RQ1
            flt_kind = CCD_FK_GP;
          end else if (q.cpl != 2'h0) begin
            flt      = 1'b1; // RQ2
            flt_kind = CCD_FK_GP;
          end else if (tgt_lin[CCD_PAGE_BITS-1:0] != '0) begin
            flt      = 1'b1; // RQ4
            flt_kind = CCD_FK_GP;
          end else if (tgt_seg_err || par_seg_err) begin
            flt      = 1'b1; // RQ14 RQ15
            flt_kind = CCD_FK_GP;
          end else begin
            d.xlat_req.valid = 1'b1;
            d.xlat_req.acc   = CCD_ACC_NONENC_RW; // RQ16
            d.xlat_req.addr  = tgt_lin;
            d.st             = CCD_S_WAIT_T;
          end
        end
      end
      CCD_S_WAIT_T: begin
        if (xlat_rsp.valid) begin
          d.t_info         = xlat_rsp;
          d.xlat_req.valid = 1'b1;
          d.xlat_req.acc   = CCD_ACC_ENC_RD; // RQ16
          d.xlat_req.addr  = par_lin;
          d.st             = CCD_S_WAIT_P;
        end
      end
      CCD_S_WAIT_P: begin
        if (xlat_rsp.valid) begin
          d.p_info = xlat_rsp;
          d.st     = CCD_S_CHECK;
        end
      end
      CCD_S_CHECK: begin
        if (!q.t_info.in_epc) begin
          flt      = 1'b1; // RQ5
          flt_kind = CCD_FK_PF;
          flt_code = CCD_ENCLAVE_FAULT_CODE;
          flt_addr = tgt_lin;
        end else if (!q.p_info.in_epc) begin
          flt      = 1'b1; // RQ5
          flt_kind = CCD_FK_PF;
          flt_code = CCD_ENCLAVE_FAULT_CODE;
          flt_addr = par_lin;
        end else if (q.t_info.busy) begin
          ext     = 1'b1; // RQ6
          ext_zf  = 1'b1;
          ext_res = CCD_RES_PAGE_CONFLICT;
        end else if (!q.t_info.meta_valid) begin
          flt      = 1'b1; // RQ7
          flt_kind = CCD_FK_PF;
          flt_code = CCD_ENCLAVE_FAULT_CODE;
          flt_addr = tgt_lin;
        end else if (!child_type && (q.t_info.ptype != CCD_PT_CONTROL)) begin
          flt      = 1'b1; // RQ9
          flt_kind = CCD_FK_PF;
          flt_code = CCD_ENCLAVE_FAULT_CODE;
          flt_addr = tgt_lin;
        end else if (derived != q.p_info.phys) begin
          flt      = 1'b1; // RQ10
          flt_kind = CCD_FK_GP;
        end else if (!q.p_info.meta_valid || (q.p_info.ptype != CCD_PT_CONTROL)) begin
          flt      = 1'b1; // RQ11
          flt_kind = CCD_FK_PF;
          flt_code = CCD_ENCLAVE_FAULT_CODE;
          flt_addr = par_lin;
        end else begin
          d.derived_parent_address = derived; // RQ17
          d.cnt_req.valid          = 1'b1; // RQ12
          d.cnt_req.inc            = 1'b0;
          d.cnt_req.locked         = 1'b1;
          d.cnt_req.addr           = derived;
          d.st                     = CCD_S_WAIT_DEC;
        end
      end
      CCD_S_WAIT_DEC: begin
        if (cnt_rsp.valid) begin
          d.temp_child_count = cnt_rsp.value; // RQ17
          if (cnt_rsp.value == 64'h0) begin
            // The memory has already wrapped; put the count back before exit.
            d.cnt_req.valid  = 1'b1; // RQ12
            d.cnt_req.inc    = 1'b1;
            d.cnt_req.locked = 1'b1;
            d.cnt_req.addr   = q.derived_parent_address;
            d.st             = CCD_S_WAIT_INC;
          end else begin
            ext     = 1'b1; // RQ13
            ext_zf  = 1'b0;
            ext_res = CCD_RES_OK;
          end
        end
      end
      CCD_S_WAIT_INC: begin
        if (cnt_rsp.valid) begin
          ext     = 1'b1; // RQ12
          ext_zf  = 1'b1;
          ext_res = CCD_RES_INVALID_COUNTER;
        end
      end
      default: begin
        d.st = CCD_S_IDLE;
      end
    endcase

    // Faults leave flags and result untouched, like an exception would.
    if (flt) begin
      d.fault_kind = flt_kind;
      d.fault_code = flt_code;
      d.fault_addr = flt_addr;
      d.ev_fault   = 1'b1;
      d.st         = CCD_S_IDLE;
    end
    if (ext) begin
      d.result           = ext_res; // RQ13
      d.flags[CCD_F_ZF]  = ext_zf; // RQ13
      d.flags[CCD_F_CF]  = 1'b0; // RQ18
      d.flags[CCD_F_PF]  = 1'b0; // RQ18
      d.flags[CCD_F_AF]  = 1'b0; // RQ18
      d.flags[CCD_F_OF]  = 1'b0; // RQ18
      d.flags[CCD_F_SF]  = 1'b0; // RQ18
      d.fault_kind       = CCD_FK_NONE;
      d.fault_code       = '0;
      d.fault_addr       = '0;
      d.ev_done          = 1'b1;
      d.st               = CCD_S_IDLE;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      q           <= '0;
      q.st        <= CCD_S_IDLE;
      q.flags     <= CCD_FLAGS_RESET;
      q.hreadyout <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.hreadyout;
  assign hresp     = 1'b0;
  assign hrdata    = q.hrdata;
  assign xlat_req  = q.xlat_req;
  assign cnt_req   = q.cnt_req;

endmodule // ccd_child_dec

// ==== ccd_pkg.sv ====
// Purpose: Shared constants and carriers of the child count decrement leaf.
// Assumes: 32-bit register bus, 64-bit addresses and counter.
// Notes:   All offsets are byte addresses of aligned words.
package ccd_pkg;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] CCD_OFF_CTRL     = 8'h00;
  localparam logic [7:0] CCD_OFF_LEAF     = 8'h04;
  localparam logic [7:0] CCD_OFF_TGT_LO   = 8'h08;
  localparam logic [7:0] CCD_OFF_TGT_HI   = 8'h0c;
  localparam logic [7:0] CCD_OFF_PAR_LO   = 8'h10;
  localparam logic [7:0] CCD_OFF_PAR_HI   = 8'h14;
  localparam logic [7:0] CCD_OFF_DS_BASE  = 8'h18;
  localparam logic [7:0] CCD_OFF_DS_LIMIT = 8'h1c;
  localparam logic [7:0] CCD_OFF_RESULT   = 8'h20;
  localparam logic [7:0] CCD_OFF_FLAGS    = 8'h24;
  localparam logic [7:0] CCD_OFF_FAULT    = 8'h28;
  localparam logic [7:0] CCD_OFF_FADDR_LO = 8'h2c;
  localparam logic [7:0] CCD_OFF_FADDR_HI = 8'h30;
  localparam logic [7:0] CCD_OFF_STATUS   = 8'h34;
  localparam logic [7:0] CCD_OFF_MASK     = 8'h38;
  localparam logic [7:0] CCD_OFF_FEATURE  = 8'h3c;

  localparam int CCD_CTRL_START       = 0;
  localparam int CCD_CTRL_CPL_LSB     = 1;
  localparam int CCD_CTRL_MODE64      = 3;
  localparam int CCD_CTRL_DS_UNUSABLE = 4;
  localparam int CCD_CTRL_BUSY        = 8;
  localparam int CCD_FEAT_BIT         = 5;
  localparam int CCD_FAULT_CODE_LSB   = 16;
  localparam int CCD_ST_DONE          = 0;
  localparam int CCD_ST_FAULT         = 1;
  localparam int CCD_NUM_EV           = 2;

  // Flag positions in the 12-bit flags word.
  localparam int CCD_F_CF = 0;
  localparam int CCD_F_PF = 2;
  localparam int CCD_F_AF = 4;
  localparam int CCD_F_ZF = 6;
  localparam int CCD_F_SF = 7;
  localparam int CCD_F_OF = 11;

  localparam logic [31:0] CCD_LEAF_DEC             = 32'h0000_0000;
  localparam logic [31:0] CCD_RES_OK               = 32'h0000_0000;
  localparam logic [31:0] CCD_RES_PAGE_CONFLICT    = 32'h0000_0001;
  localparam logic [31:0] CCD_RES_INVALID_COUNTER  = 32'h0000_0002;
  localparam logic [15:0] CCD_ENCLAVE_FAULT_CODE   = 16'h8000;
  localparam logic [15:0] CCD_GP_CODE              = 16'h0000;
  localparam logic [11:0] CCD_FLAGS_RESET          = 12'h000;
  localparam logic [1:0]  CCD_MASK_RESET           = 2'h0;
  localparam int          CCD_PAGE_BITS            = 12;

  // ****************************************
  // Page types and access kinds
  // ****************************************
  localparam logic [7:0] CCD_PT_CONTROL     = 8'h00;
  localparam logic [7:0] CCD_PT_THREAD_CTRL = 8'h01;
  localparam logic [7:0] CCD_PT_REGULAR     = 8'h02;
  localparam logic [7:0] CCD_PT_TRIMMED     = 8'h04;
  localparam logic [7:0] CCD_FIRST_SHADOW_STACK_PAGE_TYPE    = 8'h05;
  localparam logic [7:0] CCD_PT_SS_LATER    = 8'h06;

  localparam logic [1:0] CCD_ACC_NONENC_RW = 2'h1;
  localparam logic [1:0] CCD_ACC_ENC_RD    = 2'h2;

  typedef enum logic [1:0] {
    CCD_FK_NONE = 2'b00,
    CCD_FK_GP   = 2'b01,
    CCD_FK_PF   = 2'b10,
    CCD_FK_UD   = 2'b11
  } ccd_fault_t;

  typedef enum logic [2:0] {
    CCD_S_IDLE     = 3'b000,
    CCD_S_WAIT_T   = 3'b001,
    CCD_S_WAIT_P   = 3'b010,
    CCD_S_CHECK    = 3'b011,
    CCD_S_WAIT_DEC = 3'b100,
    CCD_S_WAIT_INC = 3'b101
  } ccd_st_t;

  // ****************************************
  // Carriers to translation and counter memory
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [1:0]  acc;
    logic [63:0] addr;
  } ccd_xlat_req_t;

  typedef struct packed {
    logic        valid;
    logic        in_epc;
    logic        meta_valid;
    logic        busy;
    logic [7:0]  ptype;
    logic [63:0] phys;
    logic [63:0] owner;
  } ccd_xlat_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        inc;
    logic        locked;
    logic [63:0] addr;
  } ccd_cnt_req_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] value;
  } ccd_cnt_rsp_t;

endpackage

// ==== ccd_addr_check.sv ====
// Purpose: Forms a linear address through the data segment and checks it.
// Assumes: Page-sized operands; segment base ignored in 64-bit mode.
// Notes:   Pure combinational, one copy per address operand.
`timescale 1ns/1ps
module ccd_addr_check #(
  parameter int VA_BITS = 48
) (
  input  wire logic [63:0] operand,
  input  wire logic [31:0] ds_base,
  input  wire logic [31:0] ds_limit,
  input  wire logic        mode64,
  input  wire logic        ds_unusable,
  output logic      [63:0] lin,
  output logic             seg_err
);
  logic [63-VA_BITS+1:0] top_bits;
  logic [31:0]           lin32;

  // Only the data segment takes part, so an override prefix has no path in.
  assign top_bits = operand[63:VA_BITS-1]; // RQ3
  assign lin32    = ds_base + operand[31:0]; // RQ3
  assign lin      = mode64 ? operand : {32'h0000_0000, lin32}; // RQ3

  always_comb begin
    if (mode64) begin
      seg_err = ~((&top_bits) | (~|top_bits)); // RQ15
    end else begin
      seg_err = ds_unusable | (operand[31:0] > ds_limit); // RQ14
    end
  end
endmodule // ccd_addr_check

// ==== ccd_irq.sv ====
// Purpose: Sticky event bits, mask and one level interrupt.
// Assumes: Write-one-to-clear strobes arrive as one-cycle pulses.
// Notes:   An event in the clearing cycle survives the clear.
`timescale 1ns/1ps
module ccd_irq
  import ccd_pkg::*;
#(
  parameter int N = CCD_NUM_EV
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [N-1:0] event_in,
  input  wire logic [N-1:0] w1c,
  input  wire logic         mask_we,
  input  wire logic [N-1:0] mask_wdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic         irq;
  } ccd_irq_state_t;

  ccd_irq_state_t q;
  ccd_irq_state_t d;

  always_comb begin
    d        = q;
    d.status = (q.status & ~w1c) | event_in;
    if (mask_we) begin
      d.mask = mask_wdata;
    end
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign status = q.status;
  assign mask   = q.mask;
  assign irq    = q.irq;
endmodule // ccd_irq

// ==== ccd_child_dec_asserts.sv ====
// Purpose: Port assertions for the child count decrement leaf.
// Assumes: Bound to ccd_child_dec by the bench top file.
// Notes:   Watches translation, counter and register read ports.
`timescale 1ns/1ps
module ccd_child_dec_asserts
  import ccd_pkg::*;
#(
  parameter bit FEATURE_EN = 1'b1
) (
  input wire logic          clk,
  input wire logic          srst,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic          hready,
  input wire logic [31:0]   hrdata,
  input wire ccd_xlat_req_t xlat_req,
  input wire ccd_xlat_rsp_t xlat_rsp,
  input wire ccd_cnt_req_t  cnt_req,
  input wire ccd_cnt_rsp_t  cnt_rsp
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_dec;
    cnt_req.valid && !cnt_req.inc;
  endsequence
  sequence s_zero;
    cnt_rsp.valid && cnt_rsp.value == 64'h0;
  endsequence
  property p_undo;
    s_dec ##[1:20] s_zero |-> ##[1:4] cnt_req.valid && cnt_req.inc;
  endproperty
  a_undo: assert property (p_undo) else $error("no restoring increment");
  property p_lock;
    cnt_req.valid |-> cnt_req.locked ##1 !cnt_req.valid;
  endproperty
  a_lock: assert property (p_lock) else $error("counter request not locked pulse");
  property p_xpul;
    xlat_req.valid |=> !xlat_req.valid;
  endproperty
  a_xpul: assert property (p_xpul) else $error("translation request not a pulse");
  property p_conf;
    xlat_rsp.valid && xlat_rsp.busy |-> !cnt_req.valid [*8];
  endproperty
  a_conf: assert property (p_conf) else $error("counter touched on conflict");
  property p_epc;
    xlat_rsp.valid && !xlat_rsp.in_epc |-> !cnt_req.valid [*8];
  endproperty
  a_epc: assert property (p_epc) else $error("counter touched outside memory");
  property p_inval;
    xlat_rsp.valid && !xlat_rsp.meta_valid |-> !cnt_req.valid [*8];
  endproperty
  a_inval: assert property (p_inval) else $error("counter touched on invalid page");
  property p_type;
    xlat_rsp.valid && xlat_rsp.ptype == 8'h03 |-> !cnt_req.valid [*8];
  endproperty
  a_type: assert property (p_type) else $error("counter touched on bad type");
  property p_acc;
    xlat_req.valid |-> xlat_req.acc == ($past(xlat_rsp.valid) ? CCD_ACC_ENC_RD : CCD_ACC_NONENC_RW);
  endproperty
  a_acc: assert property (p_acc) else $error("bad access kind");
  property p_feat;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == CCD_OFF_FEATURE |=> hrdata[5] == FEATURE_EN;
  endproperty
  a_feat: assert property (p_feat) else $error("feature bit wrong");
endmodule // ccd_child_dec_asserts

// ==== test_ccd_child_dec.sv ====
// Purpose: Self-checking bench for the child count decrement leaf.
// Assumes: Translation is identity and answered one cycle late.
// Notes:   The counter model lives in the bench as cv.
`timescale 1ns/1ps
`define CHK(n,e,v) begin n_compared++; if ((v) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, v); end end
module test_ccd_child_dec
  import ccd_pkg::*;
;
  logic          clk = 0, srst = 1, hwrite = 0, hready, hreadyout, hresp, irq, ti = 1, mv = 1, bz = 0;
  logic [31:0]   haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]    htrans = 0;
  logic [7:0]    pt = CCD_PT_REGULAR, pp = CCD_PT_CONTROL;
  logic [63:0]   cv = 64'h6, own = 64'h2000;
  logic [7:0]    pts [5] = '{CCD_PT_REGULAR, CCD_PT_THREAD_CTRL, CCD_PT_TRIMMED, CCD_FIRST_SHADOW_STACK_PAGE_TYPE, CCD_PT_SS_LATER};
  int            n_errors = 0, n_compared = 0;
  ccd_xlat_req_t xq;
  ccd_xlat_rsp_t xr = '0;
  ccd_cnt_req_t  cq;
  ccd_cnt_rsp_t  cr = '0;
  assign hready = hreadyout;
  ccd_child_dec ccd_child_dec_inst (.clk, .srst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .xlat_req(xq), .xlat_rsp(xr), .cnt_req(cq), .cnt_rsp(cr), .irq);
  initial forever #12.5 clk = ~clk;
  // ****
  // Far side: translation and counter, answering one cycle late
  // ****
  always @(posedge clk) begin
    xr.valid <= 1'b0;
    cr.valid <= 1'b0;
    if (xq.valid && xq.acc == CCD_ACC_NONENC_RW)
      xr <= '{1'b1, ti, mv, bz, pt, xq.addr, own};
    else if (xq.valid)
      xr <= '{1'b1, 1'b1, 1'b1, 1'b0, pp, xq.addr, 64'h0};
    if (cq.valid) begin
      cr <= '{1'b1, cv};
      cv <= cq.inc ? cv + 64'h1 : cv - 64'h1;
    end
  end
  // ****
  // Bus and run tasks
  // ****
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic run(input logic [31:0] ctl, input logic [1:0] ek, input logic [31:0] er, input logic [63:0] ec);
    int i;
    bus(1, CCD_OFF_FLAGS, 32'hfff);
    `CHK("irq", 1'b0, irq)
    bus(1, CCD_OFF_CTRL, ctl);
    i = 0;
    q = 0;
    while (q[1:0] == 2'b00 && i < 60) begin
      bus(0, CCD_OFF_STATUS, 0);
      i++;
    end
    `CHK("status", ek == 2'h0 ? 2'h1 : 2'h2, q[1:0])
    `CHK("irq", ek == 2'h0, irq)
    bus(0, CCD_OFF_FAULT, 0);
    `CHK("fault", {ek == 2'h2 ? CCD_ENCLAVE_FAULT_CODE : CCD_GP_CODE, 14'h0, ek}, q)
    `CHK("hresp", 1'b0, hresp)
    bus(0, CCD_OFF_RESULT, 0);
    if (ek == 2'h0) `CHK("result", er, q)
    bus(0, CCD_OFF_FLAGS, 0);
    `CHK("flags", ek != 2'h0 ? 12'hfff : (er != 0 ? 12'h76a : 12'h72a), q[11:0])
    `CHK("count", ec, cv)
    bus(1, CCD_OFF_STATUS, 32'h3);
  endtask
  task automatic conclude;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Long enough for every run with all polls used up.
  initial begin
    #400us;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(1, CCD_OFF_TGT_LO, 32'h1000);
    bus(1, CCD_OFF_PAR_LO, 32'h2000);
    bus(1, CCD_OFF_DS_LIMIT, 32'hffff_ffff);
    bus(1, CCD_OFF_MASK, 32'h1);
    bus(0, CCD_OFF_FEATURE, 0);
    `CHK("feature", 32'h20, q)
    foreach (pts[i]) begin
      pt = pts[i];
      run(32'h9, 2'h0, CCD_RES_OK, 64'(5 - i));
    end
    pt = CCD_PT_CONTROL;
    run(32'h9, 2'h1, 0, 64'h1);
    bus(1, CCD_OFF_TGT_LO, 32'h2000);
    run(32'h9, 2'h0, CCD_RES_OK, 64'h0);
    run(32'h9, 2'h0, CCD_RES_INVALID_COUNTER, 64'h0);
    bus(1, CCD_OFF_TGT_LO, 32'h1000);
    pt = 8'h03;
    run(32'h9, 2'h2, 0, 64'h0);
    pt = CCD_PT_REGULAR;
    bz = 1;
    run(32'h9, 2'h0, CCD_RES_PAGE_CONFLICT, 64'h0);
    bz = 0;
    mv = 0;
    run(32'h9, 2'h2, 0, 64'h0);
    mv = 1;
    pp = CCD_PT_REGULAR;
    run(32'h9, 2'h2, 0, 64'h0);
    pp = CCD_PT_CONTROL;
    ti = 0;
    run(32'h9, 2'h2, 0, 64'h0);
    bus(1, CCD_OFF_TGT_LO, 32'h1004);
    run(32'h9, 2'h1, 0, 64'h0);
    ti = 1;
    bus(1, CCD_OFF_TGT_LO, 32'h1000);
    run(32'hf, 2'h1, 0, 64'h0);
    bus(1, CCD_OFF_LEAF, 32'h1);
    run(32'h9, 2'h1, 0, 64'h0);
    bus(1, CCD_OFF_LEAF, CCD_LEAF_DEC);
    bus(1, CCD_OFF_TGT_HI, 32'h1_0000);
    run(32'h9, 2'h1, 0, 64'h0);
    bus(1, CCD_OFF_TGT_HI, 32'h0);
    run(32'h11, 2'h1, 0, 64'h0);
    bus(1, CCD_OFF_DS_LIMIT, 32'h1800);
    run(32'h1, 2'h1, 0, 64'h0);
    bus(1, CCD_OFF_DS_LIMIT, 32'hffff_ffff);
    bus(1, CCD_OFF_DS_BASE, 32'h1000);
    bus(1, CCD_OFF_TGT_LO, 32'h0);
    bus(1, CCD_OFF_PAR_LO, 32'h1000);
    cv = 64'h5;
    run(32'h1, 2'h0, CCD_RES_OK, 64'h4);
    bus(0, 8'h40, 0);
    `CHK("unmapped", 32'h0, q)
    conclude();
  end
endmodule // test_ccd_child_dec
bind ccd_child_dec ccd_child_dec_asserts #(.FEATURE_EN(FEATURE_EN)) ccd_child_dec_asserts_inst (.clk, .srst,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .xlat_req, .xlat_rsp, .cnt_req, .cnt_rsp);
